// ==== rtl/ebt_pkg.sv ====
// Purpose: constants for the external bus cycle timing sequencer
// Assumes: 32-bit classic wishbone register access
// Notes: offsets are byte addresses of aligned words
package ebt_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] EBT_CFG_BASE = 8'h00;
	localparam logic [7:0] EBT_CTRL_OFF = 8'h10;
	localparam logic [7:0] EBT_STAT_OFF = 8'h14;
	localparam int EBT_NUM_CS = 4;
	// ---------------------------------------------------------------
	// chip_select_timing_config fields
	// ---------------------------------------------------------------
	localparam int EBT_F_AB_LSB = 0;
	localparam int EBT_F_AB_W = 1;
	localparam int EBT_F_WIN_LSB = 1;
	localparam int EBT_F_WIN_W = 2;
	localparam int EBT_F_C_LSB = 3;
	localparam int EBT_F_C_W = 2;
	localparam int EBT_F_D_LSB = 5;
	localparam int EBT_F_E_LSB = 6;
	localparam int EBT_F_E_W = 5;
	localparam int EBT_F_RDY_LSB = 11;
	localparam int EBT_F_F_LSB = 12;
	localparam int EBT_F_F_W = 2;
	localparam int EBT_CFG_W = 14;
	localparam logic [13:0] EBT_CFG_RST = 14'h0000;
	// ---------------------------------------------------------------
	// control fields (write 1 to start a cycle)
	// ---------------------------------------------------------------
	localparam int EBT_C_START = 0;
	localparam int EBT_C_CS_LSB = 1;
	localparam int EBT_CS_W = 2;
	// ---------------------------------------------------------------
	// phase encoding
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		EBT_IDLE = 3'b000,
		EBT_AB = 3'b001,
		EBT_C = 3'b010,
		EBT_D = 3'b011,
		EBT_E = 3'b100,
		EBT_F = 3'b101
	} ebt_phase_t;
endpackage : ebt_pkg

// ==== rtl/ebt_wb_if.sv ====
// Purpose: wishbone slave signal bundle between the top and its decoder
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface ebt_wb_if;
	logic we;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic wr_stb;
	logic [31:0] rdat;
	modport top (output we, output adr, output wdat, output wr_stb,
		input rdat);
	modport regs (input we, input adr, input wdat, input wr_stb,
		output rdat);
endinterface : ebt_wb_if

// ==== rtl/ebt_cfg_regs.sv ====
// Purpose: per-chip-select timing configuration storage
// Assumes: writes arrive as one-cycle strobes from the bus slave
// Notes: full word writes only, sel is checked by the top
`timescale 1ns/1ps
module ebt_cfg_regs
	import ebt_pkg::*;
#(
	parameter int NUM_CS = EBT_NUM_CS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register access
	ebt_wb_if.regs bus,
	// selected configuration
	input wire logic [EBT_CS_W-1:0] sel_cs_i,
	output logic [EBT_CFG_W-1:0] cfg_o
);
	logic [EBT_CFG_W-1:0] cfg_q [NUM_CS];
	logic [EBT_CFG_W-1:0] cfg_d [NUM_CS];
	// ---------------------------------------------------------------
	// storage, one word per chip select
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_CS; i++) begin
			cfg_d[i] = cfg_q[i];
			if (bus.wr_stb && bus.we
				&& bus.adr == EBT_CFG_BASE + 8'(4*i)) begin
				cfg_d[i] = bus.wdat[EBT_CFG_W-1:0];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_CS; i++) begin
			if (rst_i) begin
				cfg_q[i] <= EBT_CFG_RST;
			end else begin
				cfg_q[i] <= cfg_d[i];
			end
		end
	end
	always_comb begin
		bus.rdat = 32'h0000_0000;
		for (int i = 0; i < NUM_CS; i++) begin
			if (bus.adr == EBT_CFG_BASE + 8'(4*i)) begin
				bus.rdat = {18'h0, cfg_q[i]};
			end
		end
	end
	assign cfg_o = cfg_q[sel_cs_i];
endmodule : ebt_cfg_regs

// ==== rtl/ebt_seq.sv ====
// Purpose: external bus cycle phase sequencer with wishbone registers
// Assumes: one system clock; ready input synchronous to it
// Notes: a cycle is started by software through the control register
`timescale 1ns/1ps
module ebt_seq
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// external bus
	input wire logic ready_i,
	output logic [2:0] phase_o,
	output logic [EBT_CS_W-1:0] cs_o,
	output logic busy_o
);
	ebt_wb_if wb ();
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [EBT_CFG_W-1:0] cfg;
	ebt_phase_t ph_q, ph_d;
	logic [5:0] cnt_q, cnt_d;
	logic [EBT_CS_W-1:0] cs_q, cs_d, last_cs_q, last_cs_d;
	logic [EBT_CFG_W-1:0] cur_q, cur_d;
	logic start;
	// busy is registered so the output comes straight from a flip-flop
	logic busy_q, busy_d;
	logic [5:0] ab_len, c_len, d_len, e_len, f_len;
	// ---------------------------------------------------------------
	// wishbone slave: ack one cycle after the request, then drop
	// ---------------------------------------------------------------
	assign wb.we = we_i;
	assign wb.adr = adr_i;
	assign wb.wdat = dat_i;
	assign wb.wr_stb = cyc_i && stb_i && we_i && !ack_q && sel_i == 4'hF;
	assign start = wb.wr_stb && adr_i == EBT_CTRL_OFF
		&& dat_i[EBT_C_START] && ph_q == EBT_IDLE;
	ebt_cfg_regs #(.NUM_CS(EBT_NUM_CS)) u_cfg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus(wb),
		.sel_cs_i(ph_q == EBT_IDLE ? dat_i[EBT_C_CS_LSB +: EBT_CS_W] : cs_q),
		.cfg_o(cfg)
	);
	always_comb begin
		ack_d = cyc_i && stb_i && !ack_q;
		dat_d = dat_q;
		if (cyc_i && stb_i && !ack_q) begin
			if (adr_i == EBT_STAT_OFF) begin
				dat_d = {26'h0, last_cs_q, busy_q, ph_q};
			end else if (adr_i == EBT_CTRL_OFF) begin
				dat_d = {29'h0, cs_q, 1'b0};
			end else begin
				dat_d = wb.rdat;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end
	assign ack_o = ack_q;
	assign dat_o = dat_q;
	// ---------------------------------------------------------------
	// phase lengths from the latched configuration
	// ---------------------------------------------------------------
	always_comb begin
		ab_len = 6'(cur_q[EBT_F_AB_LSB +: EBT_F_AB_W]) + 6'h01;
		if (cs_q != last_cs_q) begin
			ab_len = ab_len + 6'(cur_q[EBT_F_WIN_LSB +: EBT_F_WIN_W]);
		end
		c_len = 6'(cur_q[EBT_F_C_LSB +: EBT_F_C_W]);
		d_len = 6'(cur_q[EBT_F_D_LSB]);
		e_len = 6'(cur_q[EBT_F_E_LSB +: EBT_F_E_W]) + 6'h01;
		f_len = 6'(cur_q[EBT_F_F_LSB +: EBT_F_F_W]);
	end
	// ---------------------------------------------------------------
	// sequencer: counts whole clocks per phase
	// ---------------------------------------------------------------
	// the window adder compares against the previous cycle's select;
	// the first cycle after reset counts as a window change only if
	// it does not target select zero
	always_comb begin
		ph_d = ph_q;
		cnt_d = cnt_q + 6'h01;
		cs_d = cs_q;
		cur_d = cur_q;
		last_cs_d = last_cs_q;
		unique case (ph_q)
			EBT_IDLE: begin
				cnt_d = 6'h00;
				if (start) begin
					cs_d = dat_i[EBT_C_CS_LSB +: EBT_CS_W];
					cur_d = cfg;
					ph_d = EBT_AB;
					cnt_d = 6'h01;
				end
			end
			EBT_AB: begin
				if (cnt_q >= ab_len) begin
					cnt_d = 6'h01;
					if (c_len != 6'h00) ph_d = EBT_C;
					else if (d_len != 6'h00) ph_d = EBT_D;
					else ph_d = EBT_E;
				end
			end
			EBT_C: begin
				if (cnt_q >= c_len) begin
					cnt_d = 6'h01;
					ph_d = (d_len != 6'h00) ? EBT_D : EBT_E;
				end
			end
			EBT_D: begin
				cnt_d = 6'h01;
				ph_d = EBT_E;
			end
			EBT_E: begin
				if (cnt_q >= e_len) begin
					cnt_d = cnt_q;
					// stretched by the external module while ready is low and the config ready bit is set
					if (!cur_q[EBT_F_RDY_LSB] || ready_i) begin
						cnt_d = 6'h01;
						last_cs_d = cs_q;
						ph_d = (f_len != 6'h00) ? EBT_F : EBT_IDLE;
					end
				end
			end
			EBT_F: begin
				if (cnt_q >= f_len) begin
					cnt_d = 6'h00;
					ph_d = EBT_IDLE;
				end
			end
			default: begin
				ph_d = EBT_IDLE;
				cnt_d = 6'h00;
			end
		endcase
		busy_d = ph_d != EBT_IDLE;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= EBT_IDLE;
			cnt_q <= 6'h00;
			cs_q <= '0;
			last_cs_q <= '0;
			cur_q <= EBT_CFG_RST;
			busy_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			cs_q <= cs_d;
			last_cs_q <= last_cs_d;
			cur_q <= cur_d;
			busy_q <= busy_d;
		end
	end
	assign phase_o = ph_q;
	assign cs_o = cs_q;
	assign busy_o = busy_q;
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_in_e;
		ph_q == EBT_E;
	endsequence
	a_phase_order: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_C && ph_d != EBT_C |-> ph_d inside {EBT_D, EBT_E})
		else $error("bad phase after command");
	a_start_ab: assert property (@(posedge clk_i) disable iff (rst_i)
		start |=> ph_q == EBT_AB)
		else $error("start not entering setup");
	a_ab_len: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_AB |-> cnt_q <= 6'd6)
		else $error("setup too long");
	a_d_len: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_D |=> ph_q == EBT_E)
		else $error("data setup over one clock");
	a_e_min: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ph_q == EBT_E) |-> s_in_e ##1 (ph_q == EBT_E
		|| cur_q[EBT_F_E_LSB +: EBT_F_E_W] == 5'h00))
		else $error("access shorter than programmed");
	a_ready_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_E && cnt_q >= e_len && cur_q[EBT_F_RDY_LSB] && !ready_i
		|=> s_in_e)
		else $error("access left without ready");
	a_f_len: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_F |-> cnt_q <= 6'd3)
		else $error("hold too long");
	a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_AB && $past(ph_q) == EBT_AB |-> cnt_q == $past(cnt_q)
		+ 6'h01)
		else $error("setup count not per clock");
	a_skip_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		ph_q == EBT_C |-> c_len != 6'h00)
		else $error("zero command phase entered");
endmodule : ebt_seq

// ==== test/ebt_ready_model.sv ====
// Purpose: external module model that answers with ready
// Assumes: ready is only meaningful in the access phase
// Notes: ready toggles outside access, so a stale level is never trusted
`timescale 1ns/1ps
module ebt_ready_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus cycle view
	input wire logic [2:0] phase_i,
	input wire logic [7:0] dly_i,
	output logic ready_o
);
	logic [7:0] cnt_q;
	logic tog_q;
	always_ff @(posedge clk_i) begin
		tog_q <= rst_i ? 1'b0 : !tog_q;
		cnt_q <= (phase_i == 3'h4) ? cnt_q + 8'h01 : 8'h00;
	end
	// a large delay stands for a slow module
	assign ready_o = (phase_i == 3'h4) ? (cnt_q >= dly_i) : tog_q;
endmodule : ebt_ready_model

// ==== test/tb_external_bus_cycle_timing.sv ====
// Purpose: register and phase timing tests of the sequencer
// Assumes: ack one cycle after a request is taken
// Notes: phase lengths counted by a monitor at each clock edge
`timescale 1ns/1ps
module tb_external_bus_cycle_timing
	import ebt_pkg::*;
();
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00, dly = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	logic ack_o, ready_i, busy_o;
	logic [2:0] phase_o, prv = 3'h0;
	logic [EBT_CS_W-1:0] cs_o;
	int n_mismatch = 0, total_checks = 0;
	int cnt [8];
	always #12.5 clk_i = !clk_i;
	ebt_seq uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
		.ack_o(ack_o), .ready_i(ready_i), .phase_o(phase_o), .cs_o(cs_o),
		.busy_o(busy_o));
	ebt_ready_model ext (.clk_i(clk_i), .rst_i(rst_i), .phase_i(phase_o),
		.dly_i(dly), .ready_o(ready_i));
	// ---------------------------------------------------------------
	// checking
	// ---------------------------------------------------------------
	task test_done;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task fail(input string m);
		n_mismatch++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask : fail
	task check_val(input string m, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) fail(m);
	endtask : check_val
	task check_rng(input string m, input int got, lo, hi);
		total_checks++;
		if (got < lo || got > hi) fail(m);
	endtask : check_rng
	always @(posedge clk_i) begin
		if (!rst_i && phase_o !== prv && phase_o !== 3'h0 && !(phase_o > prv))
			fail("phase out of order");
		prv = phase_o;
		cnt[phase_o]++;
	end
	// ---------------------------------------------------------------
	// bus access and one bus cycle
	// ---------------------------------------------------------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) fail("no ack");
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task run(input logic [1:0] cs, input int ab, win, c, d, e, rdy, f, dl,
		input bit chg);
		int n, lo;
		dly <= 8'(dl);
		wb(1'b1, EBT_CFG_BASE + {cs, 2'b00},
			32'(ab | win << 1 | c << 3 | d << 5 | e << 6 | rdy << 11 | f << 12),
			4'hF);
		cnt = '{default: 0};
		wb(1'b1, EBT_CTRL_OFF, {29'h0, cs, 1'b1}, 4'hF);
		// a long cycle leaves room to try a refused restart
		if (e > 20) begin
			wb(1'b1, EBT_CTRL_OFF, 32'h7, 4'hF);
			wb(1'b0, EBT_STAT_OFF, 32'h0, 4'hF);
			check_val("busy flag", rd & 32'h8, 32'h8);
		end
		check_val("chip select", 32'(cs_o), 32'(cs));
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (busy_o !== 1'b0 && n < 400);
		if (n >= 400) fail("cycle hangs");
		lo = (rdy != 0 && dl > e + 1) ? dl : e + 1;
		check_rng("setup", cnt[1], 1 + ab + (chg ? win : 0),
			1 + ab + (chg ? win : 0));
		check_rng("command", cnt[2], c, c);
		check_rng("data setup", cnt[3], d, d);
		check_rng("access", cnt[4], lo, rdy != 0 ? lo + 2 : lo);
		check_rng("hold", cnt[5], f, f);
		wb(1'b0, EBT_STAT_OFF, 32'h0, 4'hF);
		check_val("status", rd, {26'h0, cs, 4'h0});
		wb(1'b0, EBT_CTRL_OFF, 32'h0, 4'hF);
		check_val("control", rd, {29'h0, cs, 1'b0});
	endtask : run
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		#(25 * 20000);
		fail("watchdog");
		test_done();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0, 4'hF);
			check_val("config reset", rd, 32'h0);
		end
		wb(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
		wb(1'b0, 8'h04, 32'h0, 4'hF);
		check_val("config rw", rd, 32'h3FFF);
		wb(1'b1, 8'h04, 32'h0, 4'h3);
		wb(1'b0, 8'h04, 32'h0, 4'hF);
		check_val("partial write", rd, 32'h3FFF);
		wb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
		wb(1'b0, 8'h20, 32'h0, 4'hF);
		check_val("unmapped", rd, 32'h0);
		run(2'h0, 0, 3, 0, 0, 0, 0, 0, 200, 1'b0);
		run(2'h1, 1, 3, 3, 1, 31, 0, 3, 200, 1'b1);
		run(2'h1, 1, 3, 3, 1, 31, 0, 3, 200, 1'b0);
		run(2'h2, 0, 2, 1, 0, 4, 1, 1, 12, 1'b1);
		run(2'h3, 1, 1, 2, 1, 2, 1, 2, 0, 1'b1);
		test_done();
	end
endmodule : tb_external_bus_cycle_timing
